/* File: logic/ppc_pkg.sv */
// How it works
// - Four 2 KB block RAM regions, one per class, 8192 bytes.
// - Takes one-Dword memory 32/64 and I/O reads and writes.
// - Memory region chosen by the three-bit target_region_select field; I/O always uses the I/O region.
// - Each valid memory or I/O read returns one Dword completion.
// - Each I/O write returns a successful completion without data.
// - Write ea8/aaaa_bbbb to region zero starts an outbound memory read.
// - Write eec/cccc_dddd to region zero requests a legacy interrupt.
// - Write eec/eeee_ffff to region zero requests an MSI.
// - Write eec/dead_beef to region zero requests an MSI-X.
// - A one-Dword write stores its payload at the addressed RAM word.
// - Builds for 64, 128 or 256 bit streams.
// - Target only, apart from the pattern-triggered requests.
// - Longer memory requests are drained fully and dropped silently.
// - Addresses beyond 2 KB wrap onto the region.
// - request_stream_ready stays low while a RAM write is done.
`default_nettype none
package ppc_pkg;
    localparam int REGION_WORDS = 512;
    localparam int NUM_REGIONS = 4;
    localparam int DATA_W_DEF = 64;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam logic [3:0] REQ_MEM_RD = 4'h0;
    localparam logic [3:0] REQ_MEM_WR = 4'h1;
    localparam logic [3:0] REQ_IO_RD = 4'h2;
    localparam logic [3:0] REQ_IO_WR = 4'h3;
    localparam logic [2:0] BAR_REGION0 = 3'h0;
    localparam logic [2:0] BAR_MEM64 = 3'h1;
    localparam logic [2:0] BAR_EROM = 3'h6;
    localparam logic [1:0] RGN_ZERO = 2'h0;
    localparam logic [1:0] RGN_MEM64 = 2'h1;
    localparam logic [1:0] RGN_IO = 2'h2;
    localparam logic [1:0] RGN_EROM = 2'h3;
    localparam logic [11:0] TRIG_RD_ADDR = 12'hea8;
    localparam logic [11:0] TRIG_INT_ADDR = 12'heec;
    localparam logic [31:0] TRIG_RD_DATA = 32'haaaa_bbbb;
    localparam logic [31:0] TRIG_LEG_DATA = 32'hcccc_dddd;
    localparam logic [31:0] TRIG_MSI_DATA = 32'heeee_ffff;
    localparam logic [31:0] TRIG_MSIX_DATA = 32'hdead_beef;
    localparam logic [2:0] CPL_STATUS_SC = 3'h0;

    typedef enum {ST_RECV, ST_PROC, ST_PUSH} ppc_state_t;

    typedef struct packed {
        logic [31:0] data;
        logic rsvd1;
        logic [2:0] attr;
        logic [2:0] tc;
        logic [5:0] aperture;
        logic [2:0] target_region_select;
        logic [7:0] func;
        logic [7:0] tag;
        logic [15:0] rid;
        logic rsvd0;
        logic [3:0] req_type;
        logic [10:0] dw_cnt;
        logic [61:0] addr;
        logic [1:0] at;
    } ppc_cq_t;

    typedef struct packed {
        logic [31:0] data;
        logic ecrc;
        logic [2:0] attr;
        logic [2:0] tc;
        logic cid_en;
        logic [15:0] cid;
        logic [7:0] tag;
        logic [15:0] rid;
        logic rsvd3;
        logic poison;
        logic [2:0] status;
        logic [10:0] dw_cnt;
        logic [2:0] rsvd2;
        logic [12:0] byte_cnt;
        logic [5:0] rsvd1;
        logic [1:0] at;
        logic rsvd0;
        logic [6:0] lower_addr;
    } ppc_cc_t;

    typedef struct packed {
        logic ecrc;
        logic [2:0] attr;
        logic [2:0] tc;
        logic rid_en;
        logic [15:0] cid;
        logic [7:0] tag;
        logic [15:0] rid;
        logic poison;
        logic [3:0] req_type;
        logic [10:0] dw_cnt;
        logic [61:0] addr;
        logic [1:0] at;
    } ppc_rq_t;

    // Returns {hit, region}; a miss means the request gets no completion.
    function automatic logic [2:0] ppc_region(input logic [3:0] rtype,
                                              input logic [2:0] bar);
        if (rtype == REQ_IO_RD || rtype == REQ_IO_WR) begin
            return {1'b1, RGN_IO};
        end
        case (bar)
            BAR_REGION0: return {1'b1, RGN_ZERO};
            BAR_MEM64: return {1'b1, RGN_MEM64};
            BAR_EROM: return {1'b1, RGN_EROM};
            default: return 3'h0;
        endcase
    endfunction : ppc_region

    // Byte count and first byte offset of a one-Dword request.
    function automatic logic [2:0] ppc_byte_cnt(input logic [3:0] be);
        casez (be)
            4'b1??1: return 3'h4;
            4'b01?1, 4'b1?10: return 3'h3;
            4'b0011, 4'b0110, 4'b1100: return 3'h2;
            default: return 3'h1;
        endcase
    endfunction : ppc_byte_cnt

    function automatic logic [1:0] ppc_low_off(input logic [3:0] be);
        casez (be)
            4'b???1: return 2'h0;
            4'b??10: return 2'h1;
            4'b?100: return 2'h2;
            4'b1000: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction : ppc_low_off
endpackage : ppc_pkg
`default_nettype wire

/* File: logic/ppc_fifo.sv */
`default_nettype none
module ppc_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = cnt_reg != FULL;
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rp_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wp_next = (wp_reg == LAST) ? '0 : wp_reg + 1'b1;
        end
        if (pop) begin
            rp_next = (rp_reg == LAST) ? '0 : rp_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end
endmodule : ppc_fifo
`default_nettype wire

/* File: logic/ppc_completer.sv */
`default_nettype none
module ppc_completer #(
    parameter int DATA_W = ppc_pkg::DATA_W_DEF,
    parameter int FIFO_DEPTH = ppc_pkg::FIFO_DEPTH_DEF,
    parameter logic [63:0] OUT_RD_ADDR = 64'h0
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [DATA_W-1:0] CQ_TDATA,
    input wire logic CQ_TVALID,
    input wire logic CQ_TLAST,
    input wire logic [3:0] CQ_FIRST_BE,
    output logic REQUEST_STREAM_READY,
    output logic [DATA_W-1:0] CC_TDATA,
    output logic CC_TVALID,
    output logic CC_TLAST,
    input wire logic CC_TREADY,
    output logic [DATA_W-1:0] RQ_TDATA,
    output logic RQ_TVALID,
    output logic RQ_TLAST,
    input wire logic RQ_TREADY,
    output logic LEGACY_INT_REQ,
    input wire logic LEGACY_INT_SENT,
    output logic MSI_REQ,
    input wire logic MSI_SENT,
    output logic MSIX_REQ,
    input wire logic MSIX_SENT
);
    import ppc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Widths derived from the stream width.
    localparam int DESC_W = $bits(ppc_cq_t);
    localparam int CAP_BEATS = (DESC_W + DATA_W - 1) / DATA_W;
    localparam int CAP_W = CAP_BEATS * DATA_W;
    localparam int OUT_BEATS = (DATA_W >= 128) ? 1 : 128 / DATA_W;
    localparam int SH_W = OUT_BEATS * DATA_W;
    localparam logic [1:0] OUT_N = 2'(OUT_BEATS);
    localparam logic [1:0] CAP_N = 2'(CAP_BEATS);
    localparam int MEM_WORDS = NUM_REGIONS * REGION_WORDS;

    ////////////////////////////////////////////////////////////////////
    // Request capture and decode.
    ppc_state_t state_reg, state_next;
    logic [CAP_W-1:0] cap_reg, cap_next;
    logic [1:0] beat_reg, beat_next;
    logic [3:0] be_reg, be_next;
    ppc_cq_t desc;
    logic [2:0] rgn;
    logic one_dw, is_wr, is_rd, is_io_wr, is_io;
    logic do_wr, do_rd, in_proc;
    logic [10:0] mem_addr;
    logic [11:0] byte_addr;
    logic zero_wr;
    logic trig_rd, trig_leg, trig_msi, trig_msix;

    assign desc = ppc_cq_t'(cap_reg[DESC_W-1:0]);
    assign rgn = ppc_region(desc.req_type, desc.target_region_select);
    assign one_dw = desc.dw_cnt == 11'h1;
    assign is_wr = desc.req_type == REQ_MEM_WR
        || desc.req_type == REQ_IO_WR;
    assign is_rd = desc.req_type == REQ_MEM_RD
        || desc.req_type == REQ_IO_RD;
    assign is_io_wr = desc.req_type == REQ_IO_WR;
    assign is_io = desc.req_type == REQ_IO_RD || is_io_wr;
    assign in_proc = state_reg == ST_PROC;
    assign do_wr = in_proc && is_wr && one_dw && rgn[2];
    assign do_rd = in_proc && is_rd && one_dw && rgn[2];
    // only the low 2 KB of the aperture
    assign mem_addr = {rgn[1:0], desc.addr[8:0]};
    assign byte_addr = {desc.addr[9:0], 2'b00};
    assign zero_wr = do_wr && rgn[1:0] == RGN_ZERO;
    assign trig_rd = zero_wr && byte_addr == TRIG_RD_ADDR
        && desc.data == TRIG_RD_DATA;
    assign trig_leg = zero_wr && byte_addr == TRIG_INT_ADDR
        && desc.data == TRIG_LEG_DATA;
    assign trig_msi = zero_wr && byte_addr == TRIG_INT_ADDR
        && desc.data == TRIG_MSI_DATA;
    assign trig_msix = zero_wr && byte_addr == TRIG_INT_ADDR
        && desc.data == TRIG_MSIX_DATA;

    assign REQUEST_STREAM_READY = state_reg == ST_RECV;

    ////////////////////////////////////////////////////////////////////
    // Completion push into the FIFO.
    ppc_cc_t push_cpl, pop_cpl;
    logic push_valid, push_ready, pop_valid, pop_ready;
    logic [31:0] rd_reg;

    assign push_valid = state_reg == ST_PUSH;

    always_comb begin
        push_cpl = '0;
        push_cpl.rid = desc.rid;
        push_cpl.tag = desc.tag;
        push_cpl.tc = desc.tc;
        push_cpl.attr = desc.attr;
        push_cpl.at = desc.at;
        push_cpl.byte_cnt = 13'(ppc_byte_cnt(be_reg));
        push_cpl.lower_addr = is_io ? 7'h0
            : {desc.addr[4:0], ppc_low_off(be_reg)};
        push_cpl.status = CPL_STATUS_SC;
        push_cpl.dw_cnt = is_rd ? 11'h1 : 11'h0;
        push_cpl.data = is_rd ? rd_reg : 32'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // Receive state machine.
    always_comb begin
        state_next = state_reg;
        cap_next = cap_reg;
        beat_next = beat_reg;
        be_next = be_reg;
        case (state_reg)
            ST_RECV: begin
                if (CQ_TVALID) begin
                    for (int i = 0; i < CAP_BEATS; i++) begin
                        if (beat_reg == 2'(i)) begin
                            cap_next[i*DATA_W +: DATA_W] = CQ_TDATA;
                        end
                    end
                    if (beat_reg == 2'h0) begin
                        be_next = CQ_FIRST_BE;
                    end
                    if (CQ_TLAST) begin
                        state_next = ST_PROC;
                        beat_next = 2'h0;
                    end else if (beat_reg != CAP_N) begin
                        beat_next = beat_reg + 2'h1;
                    end
                end
            end
            ST_PROC: begin
                if (do_rd || (do_wr && is_io_wr)) begin
                    state_next = ST_PUSH;
                end else begin
                    state_next = ST_RECV;
                end
            end
            ST_PUSH: begin
                if (push_ready) begin
                    state_next = ST_RECV;
                end
            end
            default: state_next = ST_RECV;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_reg <= ST_RECV;
            cap_reg <= '0;
            beat_reg <= 2'h0;
            be_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cap_reg <= cap_next;
            beat_reg <= beat_next;
            be_reg <= be_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Region memory; one array covers all four regions.
    // four 2 KB regions
    logic [31:0] mem [0:MEM_WORDS-1];

    always_ff @(posedge MCLK) begin
        if (do_wr) begin
            mem[mem_addr] <= desc.data;
        end
        if (do_rd) begin
            rd_reg <= mem[mem_addr];
        end
    end

    ppc_fifo #(
        .WIDTH($bits(ppc_cc_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RST_N),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_cpl),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_cpl)
    );

    ////////////////////////////////////////////////////////////////////
    // Outbound requests, interrupts and the two serialisers.
    // only these are initiated
    logic rq_pend_reg, rq_pend_next;
    logic leg_reg, leg_next, msi_reg, msi_next, msix_reg, msix_next;
    logic [SH_W-1:0] cc_sh_reg, cc_sh_next, rq_sh_reg, rq_sh_next;
    logic [1:0] cc_left_reg, cc_left_next, rq_left_reg, rq_left_next;
    logic rq_load;
    ppc_rq_t rq_desc;

    always_comb begin
        rq_desc = '0;
        rq_desc.addr = OUT_RD_ADDR[63:2];
        rq_desc.dw_cnt = 11'h1;
        rq_desc.req_type = REQ_MEM_RD;
    end

    assign pop_ready = cc_left_reg == 2'h0;
    assign rq_load = rq_pend_reg && rq_left_reg == 2'h0;

    // A trigger that lands with its acknowledge is kept, not lost.
    always_comb begin
        rq_pend_next = trig_rd || (rq_pend_reg && !rq_load);
        leg_next = trig_leg || (leg_reg && !LEGACY_INT_SENT);
        msi_next = trig_msi || (msi_reg && !MSI_SENT);
        msix_next = trig_msix || (msix_reg && !MSIX_SENT);
        cc_sh_next = cc_sh_reg;
        cc_left_next = cc_left_reg;
        rq_sh_next = rq_sh_reg;
        rq_left_next = rq_left_reg;
        if (pop_valid && pop_ready) begin
            cc_sh_next = SH_W'(pop_cpl);
            cc_left_next = OUT_N;
        end else if (cc_left_reg != 2'h0 && CC_TREADY) begin
            cc_sh_next = cc_sh_reg >> DATA_W;
            cc_left_next = cc_left_reg - 2'h1;
        end
        if (rq_load) begin
            rq_sh_next = SH_W'(rq_desc);
            rq_left_next = OUT_N;
        end else if (rq_left_reg != 2'h0 && RQ_TREADY) begin
            rq_sh_next = rq_sh_reg >> DATA_W;
            rq_left_next = rq_left_reg - 2'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rq_pend_reg <= 1'b0;
            leg_reg <= 1'b0;
            msi_reg <= 1'b0;
            msix_reg <= 1'b0;
            cc_sh_reg <= '0;
            cc_left_reg <= 2'h0;
            rq_sh_reg <= '0;
            rq_left_reg <= 2'h0;
        end else begin
            rq_pend_reg <= rq_pend_next;
            leg_reg <= leg_next;
            msi_reg <= msi_next;
            msix_reg <= msix_next;
            cc_sh_reg <= cc_sh_next;
            cc_left_reg <= cc_left_next;
            rq_sh_reg <= rq_sh_next;
            rq_left_reg <= rq_left_next;
        end
    end

    assign CC_TDATA = cc_sh_reg[DATA_W-1:0];
    assign CC_TVALID = cc_left_reg != 2'h0;
    assign CC_TLAST = cc_left_reg == 2'h1;
    assign RQ_TDATA = rq_sh_reg[DATA_W-1:0];
    assign RQ_TVALID = rq_left_reg != 2'h0;
    assign RQ_TLAST = rq_left_reg == 2'h1;
    assign LEGACY_INT_REQ = leg_reg;
    assign MSI_REQ = msi_reg;
    assign MSIX_REQ = msix_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_wr_go;
        do_wr;
    endsequence

    sequence s_rd_go;
        do_rd;
    endsequence

    property p_stall_on_write;
        s_wr_go |-> !REQUEST_STREAM_READY ##1 state_reg == ST_RECV
            || state_reg == ST_PUSH;
    endproperty
    a_stall_on_write: assert property (p_stall_on_write)
        else $error("ready not held low during RAM write");

    property p_read_cpl;
        s_rd_go |=> state_reg == ST_PUSH && push_cpl.dw_cnt == 11'h1
            && push_cpl.data == mem[$past(mem_addr)];
    endproperty
    a_read_cpl: assert property (p_read_cpl)
        else $error("read did not yield one Dword completion");

    property p_io_wr_cpl;
        s_wr_go ##0 is_io_wr |=> state_reg == ST_PUSH
            && push_cpl.dw_cnt == 11'h0
            && push_cpl.status == CPL_STATUS_SC;
    endproperty
    a_io_wr_cpl: assert property (p_io_wr_cpl)
        else $error("I/O write lacks a successful completion");

    property p_mem_wr_no_cpl;
        s_wr_go ##0 !is_io_wr |=> state_reg == ST_RECV;
    endproperty
    a_mem_wr_no_cpl: assert property (p_mem_wr_no_cpl)
        else $error("memory write produced a completion");

    property p_store;
        s_wr_go |=> mem[$past(mem_addr)] == $past(desc.data);
    endproperty
    a_store: assert property (p_store)
        else $error("write payload not stored");

    property p_out_read;
        trig_rd |=> rq_pend_reg ##1 RQ_TVALID || rq_pend_reg;
    endproperty
    a_out_read: assert property (p_out_read)
        else $error("outbound read not started");

    property p_legacy;
        trig_leg |=> LEGACY_INT_REQ;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy interrupt not requested");

    property p_msi;
        trig_msi |=> MSI_REQ && !MSIX_REQ || $past(msix_reg);
    endproperty
    a_msi: assert property (p_msi)
        else $error("MSI not requested");

    property p_msix;
        trig_msix |=> MSIX_REQ;
    endproperty
    a_msix: assert property (p_msix)
        else $error("MSI-X not requested");

    property p_drop_long;
        in_proc && !one_dw |=> state_reg == ST_RECV;
    endproperty
    a_drop_long: assert property (p_drop_long)
        else $error("long request was answered");

    property p_copy;
        push_valid && push_ready |-> push_cpl.tag == desc.tag
            && push_cpl.rid == desc.rid && push_cpl.tc == desc.tc;
    endproperty
    a_copy: assert property (p_copy)
        else $error("completion identity differs from request");

    property p_wrap;
        s_wr_go |-> mem_addr[8:0] == desc.addr[8:0]
            && mem_addr[10:9] == rgn[1:0];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("region address not wrapped to 2 KB");
endmodule : ppc_completer
`default_nettype wire

/* File: bench/ppc_core_model.sv */
`default_nettype none
module ppc_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic [127:0] cc_tdata,
    input wire logic cc_tvalid,
    output logic cc_tready,
    input wire logic [127:0] rq_tdata,
    input wire logic rq_tvalid,
    output logic rq_tready,
    input wire logic [2:0] int_req,
    output var logic [2:0] int_sent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] cpl_q [$];
    logic [127:0] rq_q [$];
    int ack_n [3];
    logic [1:0] wait_c [3];
    // One stall input backs up both streams, so the buffer can be filled.
    assign cc_tready = !stall;
    assign rq_tready = !stall;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (cc_tvalid && cc_tready) begin
            cpl_q.push_back(cc_tdata);
        end
        if (rq_tvalid && rq_tready) begin
            rq_q.push_back(rq_tdata);
        end
        // Acks arrive late on purpose: a request must hold until then.
        for (int i = 0; i < 3; i++) begin
            int_sent[i] <= 1'b0;
            if (!rst_n) begin
                wait_c[i] <= 2'h0;
            end else if (int_req[i] && !int_sent[i]) begin
                wait_c[i] <= wait_c[i] + 2'h1;
                if (wait_c[i] == 2'h3) begin
                    int_sent[i] <= 1'b1;
                    ack_n[i]++;
                end
            end
        end
    end
endmodule : ppc_core_model
`default_nettype wire

/* File: bench/ppc_completer_test.sv */
`default_nettype none
module ppc_completer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ppc_pkg::*;
    localparam logic [63:0] RD_ADDR = 64'h0000_0000_1000_0040;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic stall = 1'b0;
    logic [127:0] cq_tdata = '0, cc_tdata, rq_tdata;
    logic cq_tvalid = 1'b0, cq_tlast = 1'b0, rdy, cc_tvalid, cc_tlast;
    logic cc_tready, rq_tvalid, rq_tlast, rq_tready;
    logic [3:0] cq_be = 4'hf;
    wire [2:0] int_req;
    logic [2:0] int_sent;
    int failures = 0, compares = 0, cycles = 0;
    // Expected byte count and first byte offset for the enables in use.
    logic [12:0] exp_bc = 13'h4;
    logic [1:0] exp_lo = 2'h0;

    always #10 mclk = ~mclk;

    ppc_completer #(.DATA_W(128), .FIFO_DEPTH(8), .OUT_RD_ADDR(RD_ADDR)) DUT (
        .MCLK(mclk), .RST_N(rst_n), .CQ_TDATA(cq_tdata),
        .CQ_TVALID(cq_tvalid), .CQ_TLAST(cq_tlast), .CQ_FIRST_BE(cq_be),
        .REQUEST_STREAM_READY(rdy), .CC_TDATA(cc_tdata),
        .CC_TVALID(cc_tvalid), .CC_TLAST(cc_tlast), .CC_TREADY(cc_tready),
        .RQ_TDATA(rq_tdata), .RQ_TVALID(rq_tvalid), .RQ_TLAST(rq_tlast),
        .RQ_TREADY(rq_tready), .LEGACY_INT_REQ(int_req[0]),
        .LEGACY_INT_SENT(int_sent[0]), .MSI_REQ(int_req[1]),
        .MSI_SENT(int_sent[1]), .MSIX_REQ(int_req[2]),
        .MSIX_SENT(int_sent[2]));

    ppc_core_model core (.clk(mclk), .rst_n(rst_n), .stall(stall),
        .cc_tdata(cc_tdata), .cc_tvalid(cc_tvalid), .cc_tready(cc_tready),
        .rq_tdata(rq_tdata), .rq_tvalid(rq_tvalid), .rq_tready(rq_tready),
        .int_req(int_req), .int_sent(int_sent));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [127:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            $display("MISMATCH at %0t: timeout", $time);
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready comes from a state flop, so it is already settled at the
    // falling edge and matches what the next rising edge samples.
    task automatic beat(input logic [127:0] b, input logic l);
        @(negedge mclk);
        cq_tdata = b;
        cq_tvalid = 1'b1;
        cq_tlast = l;
        while (rdy !== 1'b1) @(negedge mclk);
        @(posedge mclk);
    endtask : beat

    task automatic send(input logic [3:0] rt, input logic [2:0] bar,
                        input logic [63:0] a, input logic [31:0] d,
                        input logic [10:0] n, input logic [7:0] tg);
        ppc_cq_t c;
        c = '{data: d, attr: 3'h2, tc: 3'h5, target_region_select: bar, tag: tg,
              rid: 16'hbe11, req_type: rt, dw_cnt: n, addr: a[63:2],
              default: '0};
        beat(c[127:0], 1'b0);
        beat({96'h0, c.data}, 1'b1);
        @(negedge mclk);
        cq_tvalid = 1'b0;
        cq_tdata = ~cq_tdata;
        chk(128'(rdy), 128'h0, "ready after last beat");
    endtask : send

    task automatic expect_cpl(input logic [7:0] tg, input logic [63:0] a,
                              input logic [31:0] d, input logic io, iow);
        ppc_cc_t e;
        logic [127:0] g;
        int k;
        k = 0;
        while (core.cpl_q.size() == 0 && k < 60) begin
            @(negedge mclk);
            k++;
        end
        g = core.cpl_q.size() > 0 ? core.cpl_q.pop_front() : 'x;
        e = '{rid: 16'hbe11, tag: tg, tc: 3'h5, attr: 3'h2,
              dw_cnt: {10'h0, !iow}, byte_cnt: exp_bc, data: d,
              lower_addr: io ? 7'h0 : {a[6:2], exp_lo}, default: '0};
        chk(128'(g[95:0]), 128'(e[95:0]), "completion header");
        if (!iow) begin
            chk(128'(g[127:96]), 128'(d), "completion data");
        end
    endtask : expect_cpl

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regions;
        logic [2:0] bars [4] = '{BAR_REGION0, BAR_MEM64, BAR_EROM, 3'h7};
        for (int i = 0; i < 3; i++) begin
            send(REQ_MEM_WR, bars[i], 64'h40, {24'h5a_0000, 8'(i)}, 11'h1,
                 8'(i));
        end
        send(REQ_IO_WR, 3'h0, 64'h40, 32'h5a00_0003, 11'h1, 8'h13);
        expect_cpl(8'h13, 64'h40, 32'h0, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            send(i < 3 ? REQ_MEM_RD : REQ_IO_RD, bars[i], 64'h40, 32'h0,
                 11'h1, 8'h20 + 8'(i));
            expect_cpl(8'h20 + 8'(i), 64'h40, {24'h5a_0000, 8'(i)}, i == 3,
                       1'b0);
        end
    endtask : t_regions

    task automatic t_wrap_drop;
        send(REQ_MEM_WR, BAR_MEM64, 64'h844, 32'hc0de_0001, 11'h1, 8'h30);
        send(REQ_MEM_WR, BAR_MEM64, 64'h44, 32'hbad0_0002, 11'h2, 8'h31);
        send(REQ_MEM_RD, BAR_MEM64, 64'h44, 32'h0, 11'h2, 8'h32);
        send(REQ_MEM_RD, 3'h2, 64'h44, 32'h0, 11'h1, 8'h33);
        // Bytes one and two only: count two, first byte offset one.
        cq_be = 4'h6;
        exp_bc = 13'h2;
        exp_lo = 2'h1;
        send(REQ_MEM_RD, BAR_MEM64, 64'h44, 32'h0, 11'h1, 8'h34);
        cq_be = 4'hf;
        expect_cpl(8'h34, 64'h44, 32'hc0de_0001, 1'b0, 1'b0);
        exp_bc = 13'h4;
        exp_lo = 2'h0;
        chk(128'(core.cpl_q.size()), 128'h0, "extra completion");
    endtask : t_wrap_drop

    task automatic t_trig;
        logic [31:0] pats [3] = '{TRIG_LEG_DATA, TRIG_MSI_DATA,
                                  TRIG_MSIX_DATA};
        logic [127:0] g;
        int n0;
        send(REQ_MEM_WR, BAR_REGION0, 64'hea8, TRIG_RD_DATA, 11'h1, 8'h40);
        repeat (6) @(negedge mclk);
        g = core.rq_q.size() > 0 ? core.rq_q.pop_front() : 'x;
        chk(128'(g[78:0]), 128'({4'h0, 11'h1, RD_ADDR[63:2], 2'h0}),
            "read request");
        for (int i = 0; i < 3; i++) begin
            n0 = core.ack_n[i];
            send(REQ_MEM_WR, BAR_REGION0, 64'heec, pats[i], 11'h1, 8'h41);
            repeat (10) @(negedge mclk);
            chk(128'({int_req, core.ack_n[i] - n0}), 128'h1,
                "interrupt");
        end
        n0 = core.ack_n[1];
        send(REQ_MEM_WR, BAR_MEM64, 64'heec, TRIG_MSI_DATA, 11'h1, 8'h42);
        repeat (10) @(negedge mclk);
        chk(128'({int_req, core.ack_n[1] - n0, core.rq_q.size()}), 128'h0,
            "side effect");
    endtask : t_trig

    // Nine completions fit in the buffer and output stage; the tenth
    // parks the request side, so ready must stay low until drained.
    task automatic t_fifo;
        stall = 1'b1;
        for (int i = 0; i < 10; i++) begin
            send(REQ_MEM_RD, BAR_MEM64, 64'h44, 32'h0, 11'h1, 8'h50 + 8'(i));
        end
        repeat (5) @(negedge mclk);
        chk(128'({rdy, cc_tvalid, cc_tlast}), 128'h3, "full buffer");
        stall = 1'b0;
        for (int i = 0; i < 10; i++) begin
            expect_cpl(8'h50 + 8'(i), 64'h44, 32'hc0de_0001, 1'b0,
                       1'b0);
        end
    endtask : t_fifo

    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        t_regions();
        t_wrap_drop();
        t_trig();
        t_fifo();
        finish_test();
    end
endmodule : ppc_completer_test
`default_nettype wire
